// ===== control_store_load_port.sv
// control-store maintenance load port: eight host byte registers and
// the writable control store behind them; host is synchronous to core_clk
//
// Function
// - Eight byte registers answer host byte or aligned word accesses.
// - Only the maintenance byte at offset one has fixed bit meaning.
// - With ram-out set, offset four addresses and offset six accesses the store.
// - The write bit copies the offset-six word to the addressed location.
// - The write bit has no effect on the store unless ram-out is set.
// - With ram-out set, reading offset six returns the addressed store word.
// - The store address covers locations zero to octal 1777.
`timescale 1ns/1ns
module control_store_load_port
  import store_load_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [2:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_byte,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_ack,
  input wire logic [STORE_AW-1:0] micro_addr,
  output logic [STORE_DW-1:0] micro_data,
  output logic [7:0] micro_reg [REG_COUNT],
  output logic run_bit,
  output logic master_clear,
  output logic ram_in_bit,
  output logic step_bit
);
  logic [7:0] regs [REG_COUNT];
  logic [7:0] wdata_b [REG_COUNT];
  logic [REG_COUNT-1:0] wen;
  logic [STORE_DW-1:0] control_store [STORE_DEPTH];
  logic [STORE_DW-1:0] rd_word_r;
  logic [15:0] rdata_nxt;
  logic ack_r;
  logic ram_out;
  logic write_rise;
  logic [STORE_AW-1:0] store_addr;
  logic [STORE_DW-1:0] store_data;
  logic [7:0] maint_nxt;

  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      wen[i] = 1'b0;
      wdata_b[i] = host_wdata[7:0];
      if (host_wr) begin
        if (host_byte) begin
          wen[i] = (host_addr == 3'(i));
          wdata_b[i] = host_wdata[7:0];
        end else if (host_addr[2:1] == 2'(i / 2)) begin
          wen[i] = 1'b1;
          wdata_b[i] = (i % 2 == 1) ? host_wdata[15:8] : host_wdata[7:0];
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_reg
      byte_reg u_reg (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .wr_en(wen[g]),
        .wr_data(wdata_b[g]),
        .q(regs[g])
      );
    end
  endgenerate

  assign maint_nxt = wdata_b[OFS_MAINT];
  assign ram_out = regs[OFS_MAINT][BIT_RAM_OUT];
  assign run_bit = regs[OFS_MAINT][BIT_RUN];
  assign master_clear = regs[OFS_MAINT][BIT_MASTER_CLEAR];
  assign ram_in_bit = regs[OFS_MAINT][BIT_RAM_IN];
  assign step_bit = regs[OFS_MAINT][BIT_STEP];
  assign micro_reg = regs;

  assign store_addr = {regs[OFS_ADDR_HI][STORE_AW-9:0], regs[OFS_ADDR_LO]};
  assign store_data = {regs[OFS_DATA_HI], regs[OFS_DATA_LO]};

  // one write per raising host write
  assign write_rise = wen[OFS_MAINT] && maint_nxt[BIT_WRITE] &&
                      !regs[OFS_MAINT][BIT_WRITE];

  // commit data word, gated by ram-out
  always_ff @(posedge core_clk) begin
    if (ce && write_rise && (maint_nxt[BIT_RAM_OUT] || ram_out)) begin
      control_store[store_addr] <= store_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      micro_data <= WORD_RESET;
      rd_word_r <= WORD_RESET;
    end else if (ce) begin
      micro_data <= control_store[micro_addr];
      rd_word_r <= control_store[store_addr];
    end
  end

  always_comb begin
    rdata_nxt = {regs[{host_addr[2:1], 1'b1}], regs[{host_addr[2:1], 1'b0}]};
    if (ram_out && host_addr[2:1] == OFS_DATA_LO[2:1]) begin
      rdata_nxt = rd_word_r;
    end
    if (host_byte && host_addr[0]) begin
      rdata_nxt = {8'h00, rdata_nxt[15:8]};
    end else if (host_byte) begin
      rdata_nxt = {8'h00, rdata_nxt[7:0]};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= WORD_RESET;
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= host_rd || host_wr;
      if (host_rd) begin
        host_rdata <= rdata_nxt;
      end
    end
  end
  assign host_ack = ack_r;

  // byte write at offset one lands in the maintenance byte
  property p_byte_write;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_wr && host_byte && host_addr == OFS_MAINT)
      |=> regs[OFS_MAINT] == $past(host_wdata[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost");

  property p_write_gated;
    @(posedge core_clk) disable iff (!rstn)
      (ce && write_rise && !maint_nxt[BIT_RAM_OUT] && !ram_out)
      |=> control_store[$past(store_addr)] == $past(control_store[store_addr]);
  endproperty
  a_write_gated: assert property (p_write_gated) else $error("store changed without ram-out");

  property p_commit;
    @(posedge core_clk) disable iff (!rstn)
      (ce && write_rise && (maint_nxt[BIT_RAM_OUT] || ram_out))
      |=> control_store[$past(store_addr)] == $past(store_data);
  endproperty
  a_commit: assert property (p_commit) else $error("store word not committed");

  property p_readback;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_rd && !host_byte && ram_out && host_addr == OFS_DATA_LO)
      |=> host_rdata == $past(rd_word_r);
  endproperty
  a_readback: assert property (p_readback) else $error("read-back mismatch");

  // offset six is a plain register while ram-out is clear
  property p_data_plain;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_rd && !host_byte && !ram_out && host_addr == OFS_DATA_LO)
      |=> host_rdata == $past({regs[OFS_DATA_HI], regs[OFS_DATA_LO]});
  endproperty
  a_data_plain: assert property (p_data_plain) else $error("plain data read wrong");

  property p_addr_range;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_wr && !host_byte && host_addr == OFS_ADDR_LO)
      |=> store_addr == $past(host_wdata[STORE_AW-1:0]);
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address not right-justified");

  property p_single;
    @(posedge core_clk) disable iff (!rstn)
      (ce && write_rise) |=> !write_rise;
  endproperty
  a_single: assert property (p_single) else $error("double write strobe");

  property p_ack;
    @(posedge core_clk) disable iff (!rstn)
      (ce && (host_rd || host_wr)) |=> host_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("missing ack");

  property p_ack_idle;
    @(posedge core_clk) disable iff (!rstn)
      (ce && !host_rd && !host_wr) |=> !host_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

  // frozen state while the enable is low
  property p_freeze;
    @(posedge core_clk) disable iff (!rstn)
      !ce |=> $stable(regs[OFS_MAINT]) && $stable(host_rdata) && $stable(host_ack);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  property p_word_write;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_wr && !host_byte && host_addr == OFS_ADDR_LO)
      |=> {regs[OFS_ADDR_HI], regs[OFS_ADDR_LO]} == $past(host_wdata);
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write split wrong");

  property p_byte_read;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_rd && host_byte) |=> host_rdata[15:8] == 8'h00;
  endproperty
  a_byte_read: assert property (p_byte_read) else $error("byte read upper lane set");

  property p_maint_bits;
    @(posedge core_clk) disable iff (!rstn)
      (ce && host_wr && host_byte && host_addr == OFS_MAINT)
      |=> run_bit == $past(host_wdata[BIT_RUN]) && step_bit == $past(host_wdata[BIT_STEP]);
  endproperty
  a_maint_bits: assert property (p_maint_bits) else $error("maintenance bit misplaced");
endmodule // control_store_load_port

// ===== store_load_pkg.sv
// constants for the control-store maintenance load port
// assumes a single 100 MHz core clock domain
package store_load_pkg;
  localparam int unsigned REG_COUNT = 8;
  localparam logic [2:0] OFS_LOW_BYTE = 3'h0;
  localparam logic [2:0] OFS_MAINT = 3'h1;
  localparam logic [2:0] OFS_ADDR_LO = 3'h4;
  localparam logic [2:0] OFS_ADDR_HI = 3'h5;
  localparam logic [2:0] OFS_DATA_LO = 3'h6;
  localparam logic [2:0] OFS_DATA_HI = 3'h7;
  localparam int unsigned STORE_AW = 10;
  localparam int unsigned STORE_DEPTH = 1024;
  localparam int unsigned STORE_DW = 16;
  localparam int unsigned BIT_RUN = 7;
  localparam int unsigned BIT_MASTER_CLEAR = 6;
  localparam int unsigned BIT_WRITE = 5;
  localparam int unsigned BIT_RAM_OUT = 2;
  localparam int unsigned BIT_RAM_IN = 1;
  localparam int unsigned BIT_STEP = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// ===== byte_reg.sv
// one byte-wide register cell with byte write enable
// assumes synchronous write strobes from the host port logic
`timescale 1ns/1ns
module byte_reg
  import store_load_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] q
);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= REG_RESET;
    end else if (ce && wr_en) begin
      q <= wr_data;
    end
  end
endmodule // byte_reg

// ===== host_model.sv
// host program model: byte and word accesses to the load port
// assumes one-cycle request pulses answered by host_ack
`timescale 1ns/1ns
module host_model (
  input wire logic core_clk,
  input wire logic host_ack,
  input wire logic [15:0] host_rdata,
  output logic [2:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic host_byte,
  output logic [15:0] host_wdata
);
  initial begin
    host_addr = 3'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_byte = 1'b0;
    host_wdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [2:0] a, input logic b,
                      input logic [15:0] d, output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q = 16'h0000;
    @(posedge core_clk);
    host_addr <= a;
    host_byte <= b;
    host_wdata <= d;
    host_wr <= w;
    host_rd <= ~w;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    // released bus shows no stale address or data
    host_wdata <= ~d;
    host_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge core_clk);
      if (host_ack === 1'b1) begin
        ok = 1'b1;
        q = host_rdata;
      end
    end
  endtask
endmodule // host_model

// ===== control_store_load_port_tb_top.sv
// bench for the control-store load port
// assumes host_model as the host program and one 100 MHz clock
`timescale 1ns/1ns
module control_store_load_port_tb_top
  import store_load_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic host_wr, host_rd, host_byte, host_ack;
  logic [2:0] host_addr;
  logic [15:0] host_wdata, host_rdata, q;
  logic [STORE_AW-1:0] micro_addr = 10'h000;
  logic [STORE_DW-1:0] micro_data;
  logic [7:0] micro_reg [REG_COUNT];
  logic [3:0] maint_bits;
  logic ok;
  int n_errors = 0;
  int compares = 0;
  logic [9:0] row_addr [3] = '{10'h000, 10'h3FF, 10'h155};
  logic [15:0] row_data [3] = '{16'h1234, 16'hFFFF, 16'h5A0F};
  control_store_load_port control_store_load_port_inst (.core_clk(core_clk), .rstn(rstn),
    .ce(ce), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_byte(host_byte), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_ack(host_ack), .micro_addr(micro_addr), .micro_data(micro_data),
    .micro_reg(micro_reg), .run_bit(maint_bits[3]), .master_clear(maint_bits[2]),
    .ram_in_bit(maint_bits[1]), .step_bit(maint_bits[0]));
  host_model host_model_inst (.core_clk(core_clk), .host_ack(host_ack),
    .host_rdata(host_rdata), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_byte(host_byte), .host_wdata(host_wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic b, input logic [15:0] d);
    logic ok;
    host_model_inst.xfer(w, a, b, d, q, ok);
    if (!ok) begin
      n_errors++;
      stop_test();
    end
  endtask
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk(host_rdata, 16'h0000);
    chk({8'h00, micro_reg[1]}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 3'h0, 1'b0, 16'h0400);
      acc(1'b1, 3'h4, 1'b0, {6'h00, row_addr[i]});
      acc(1'b1, 3'h6, 1'b0, row_data[i]);
      acc(1'b1, 3'h0, 1'b0, 16'h2400);
      acc(1'b1, 3'h0, 1'b0, 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 3'h0, 1'b0, 16'h0400);
      acc(1'b1, 3'h4, 1'b0, {6'h00, row_addr[i]});
      repeat (2) @(posedge core_clk);
      acc(1'b0, 3'h6, 1'b0, 16'h0000);
      chk(q, row_data[i]);
      acc(1'b1, 3'h0, 1'b0, 16'h0000);
      micro_addr <= row_addr[i];
      repeat (3) @(posedge core_clk);
      chk(micro_data, row_data[i]);
    end
    acc(1'b1, 3'h0, 1'b0, 16'h0400);
    acc(1'b1, 3'h4, 1'b0, 16'h0155);
    acc(1'b1, 3'h6, 1'b0, 16'hDEAD);
    acc(1'b1, 3'h0, 1'b0, 16'h0000);
    acc(1'b1, 3'h0, 1'b0, 16'h2000);
    acc(1'b1, 3'h0, 1'b0, 16'h0000);
    repeat (3) @(posedge core_clk);
    chk(micro_data, 16'h5A0F);
    acc(1'b1, 3'h2, 1'b0, 16'hBEEF);
    acc(1'b1, 3'h3, 1'b1, 16'h00A5);
    acc(1'b0, 3'h2, 1'b0, 16'h0000);
    chk(q, 16'hA5EF);
    acc(1'b0, 3'h3, 1'b1, 16'h0000);
    chk(q, 16'h00A5);
    chk({micro_reg[3], micro_reg[2]}, 16'hA5EF);
    acc(1'b1, 3'h1, 1'b1, 16'h00C3);
    chk({12'h000, maint_bits}, 16'h000F);
    // offset six reads the data register with ram-out clear
    acc(1'b0, 3'h6, 1'b0, 16'h0000);
    chk(q, 16'hDEAD);
    // enable low: request ignored, no ack
    ce <= 1'b0;
    host_model_inst.xfer(1'b1, 3'h2, 1'b0, 16'h1111, q, ok);
    chk({15'h0000, ok}, 16'h0000);
    ce <= 1'b1;
    acc(1'b0, 3'h2, 1'b0, 16'h0000);
    chk(q, 16'hA5EF);
    // mid-run reset clears registers, store kept
    rstn <= 1'b0;
    @(posedge core_clk);
    chk({micro_reg[3], micro_reg[2]}, 16'h0000);
    chk({12'h000, maint_bits}, 16'h0000);
    chk(host_rdata, 16'h0000);
    rstn <= 1'b1;
    acc(1'b0, 3'h2, 1'b0, 16'h0000);
    chk(q, 16'h0000);
    repeat (2) @(posedge core_clk);
    chk(micro_data, 16'h5A0F);
    stop_test();
  end
endmodule // control_store_load_port_tb_top
